// file: hw/osf_pkg.sv
// Package for the octal switch fault supervision logic.
// Assumes a single 50 MHz clock; shared by the design and the bench.
package osf_pkg;
   localparam int unsigned NUM_OUT       = 8;
   localparam int unsigned CLK_HZ        = 50_000_000;
   // Open-load filter window in microseconds
   localparam int unsigned FILT_MIN_US   = 100;
   localparam int unsigned FILT_MAX_US   = 300;
   // Terminal count aimed at the middle of the window
   localparam int unsigned FILT_MID_US   = (FILT_MIN_US + FILT_MAX_US) / 2;
   localparam int unsigned FILT_CYCLES   = FILT_MID_US * (CLK_HZ / 1_000_000);
   localparam int unsigned FILT_MIN_CYC  = FILT_MIN_US * (CLK_HZ / 1_000_000);
   localparam int unsigned FILT_MAX_CYC  = FILT_MAX_US * (CLK_HZ / 1_000_000);
   localparam int unsigned FRAME_BITS    = 8;
   localparam logic [7:0]  CMD_RESET     = 8'h00;
   localparam logic [7:0]  FAULT_RESET   = 8'h00;

   // Per-output analog indications
   typedef struct packed {
      logic [7:0] open_load;   // Off-state drain-source below threshold
      logic [7:0] thermal;     // Output above thermal limit
   } osf_sense_s;

   // Global supply indications
   typedef struct packed {
      logic load_ov;           // load_supply over-voltage
      logic load_uv;           // load_supply under-voltage
      logic logic_uv;          // Logic supply under-voltage
   } osf_supply_s;

   typedef enum logic [1:0] {
      OSF_IDLE,
      OSF_SHIFT
   } osf_spi_e;
endpackage

// file: hw/osf_fault_logic.sv
// Fault supervision and serial port of an eight-channel load switch.
// Assumes analog sense and supply flags arrive asynchronously on pins,
// and the serial port pins come from an external microcontroller.
// Each serial pin level must stand four clocks to be seen.
// Notes on behaviour
// - Load-supply over-voltage forces all eight outputs off at once.
// - After over-voltage clears, outputs return to their held command.
// - Open load is evaluated only while the output is commanded off.
// - Open-load reports are suppressed for a 100 to 300 us filter.
// - Each rising chip-select edge restarts the fault delay timer.
// - Open-load comparator ignored until the delay timer expires.
// - Open-load fault stays latched until read; outputs recover.
// - Thermal limit turns off only the affected output.
// - Output retries automatically after cooling while commanded on.
// - Logic-supply under-voltage turns outputs off, clears status.
// - After logic-supply recovery the status captures faults again.
// - Load-supply under-voltage leaves outputs following commands.
// - Faulted output reports one, healthy output reports zero.
// - Status shifts out MSB first, output eight on first rising edge.
// - New command bits reach outputs only on chip-select rising edge.
// - Enable low: outputs undriven, no fault detection; resume later.
`timescale 1ns/100ps
module osf_fault_logic
   import osf_pkg::*;
#(
   parameter int unsigned FILT_COUNT = FILT_CYCLES
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // Serial port pins
   input  wire logic              cs_n,
   input  wire logic              sclk,
   input  wire logic              sdi,
   output logic                   sdo,
   output logic                   sdo_oe,
   // Device control pins
   input  wire logic              enable,
   input  wire osf_supply_s       supply,
   input  wire osf_sense_s        sense,
   // Output gate drive
   output logic [NUM_OUT-1:0]     gate_on,
   output logic [NUM_OUT-1:0]     gate_drive_en,
   // Visible status
   output logic [NUM_OUT-1:0]     fault_status_reg,
   output logic                   filter_done
);
   // Elaboration checks: sense fields and frame are one bit per output,
   // and the delay timer below is 24 bits wide
   generate
      if (NUM_OUT != $bits(osf_sense_s) / 2) begin : g_bad_width
         $error("NUM_OUT does not match the sense fields");
      end
      if (FRAME_BITS != NUM_OUT) begin : g_bad_frame
         $error("FRAME_BITS must equal NUM_OUT");
      end
      if (FILT_COUNT < 1 || FILT_COUNT > 32'h00ff_ffff) begin : g_bad_count
         $error("FILT_COUNT out of range");
      end
   endgenerate

   // Two-stage synchronisers for all asynchronous pins
   // They carry no reset; reset is held far longer than they take to fill
   localparam int unsigned SW = 3 + 1 + 3 + 2 * NUM_OUT;
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   always_ff @(posedge clk) begin
      sync1_q <= {cs_n, sclk, sdi, enable, supply, sense};
      sync2_q <= sync1_q;
   end

   wire         cs_s   = sync2_q[SW-1];
   wire         sclk_s = sync2_q[SW-2];
   wire         sdi_s  = sync2_q[SW-3];
   wire         en_s   = sync2_q[SW-4];
   osf_supply_s sup_s;
   osf_sense_s  sen_s;
   assign sup_s = sync2_q[2*NUM_OUT +: 3];
   assign sen_s = sync2_q[2*NUM_OUT-1:0];

   // Edge detection on synchronised serial signals
   logic cs_prev_q;
   logic sclk_prev_q;
   // Reset to the idle levels so no false edge follows reset
   always_ff @(posedge clk) begin
      if (reset) begin
         cs_prev_q   <= 1'b1;
         sclk_prev_q <= 1'b0;
      end else begin
         cs_prev_q   <= cs_s;
         sclk_prev_q <= sclk_s;
      end
   end
   // Serial clock edges count only inside a frame
   wire cs_fall   = cs_prev_q & ~cs_s;
   wire cs_rise   = ~cs_prev_q & cs_s;
   wire sclk_rise = ~sclk_prev_q & sclk_s & ~cs_s;
   wire sclk_fall = sclk_prev_q & ~sclk_s & ~cs_s;

   // Serial shifter: status loaded on chip-select fall
   osf_spi_e          spi_q;
   logic [7:0]        shift_q;
   logic [7:0]        cmd_q;
   logic [3:0]        bits_q;
   logic [7:0]        snap_q;
   wire               frame_full = (bits_q >= 4'(FRAME_BITS));
   always_ff @(posedge clk) begin
      if (reset || sup_s.logic_uv) begin
         spi_q   <= OSF_IDLE;
         shift_q <= FAULT_RESET;
         bits_q  <= '0;
         snap_q  <= FAULT_RESET;
      end else begin
         case (spi_q)
            OSF_IDLE: begin
               if (cs_fall) begin
                  shift_q <= fault_status_reg;
                  snap_q  <= fault_status_reg;
                  bits_q  <= '0;
                  spi_q   <= OSF_SHIFT;
               end
            end
            OSF_SHIFT: begin
               if (sclk_fall) begin
                  shift_q <= {shift_q[6:0], sdi_s};
                  if (!frame_full)
                     bits_q <= bits_q + 4'd1;
               end
               if (cs_rise)
                  spi_q <= OSF_IDLE;
            end
            default: spi_q <= OSF_IDLE;
         endcase
      end
   end

   // MSB presented on each rising serial clock edge
   // sdo keeps its last bit outside a frame; sdo_oe marks it undriven
   always_ff @(posedge clk) begin
      if (reset) begin
         sdo    <= 1'b0;
         sdo_oe <= 1'b0;
      end else begin
         sdo_oe <= ~cs_s;
         if (sclk_rise)
            sdo <= shift_q[7];
      end
   end

   // Command latched only on chip-select rise
   wire cmd_load = cs_rise && spi_q == OSF_SHIFT && frame_full;
   always_ff @(posedge clk) begin
      if (reset || sup_s.logic_uv)
         cmd_q <= CMD_RESET;
      else if (cmd_load)
         cmd_q <= shift_q;
   end

   // Fault delay timer on the internal clock
   // Any chip-select rise restarts it, even one closing a short frame
   logic [23:0] timer_q;
   always_ff @(posedge clk) begin
      if (reset || cs_rise)
         timer_q <= '0;
      else if (timer_q != 24'(FILT_COUNT))
         timer_q <= timer_q + 24'd1;
   end
   wire timer_done = (timer_q == 24'(FILT_COUNT));

   always_ff @(posedge clk) begin
      if (reset)
         filter_done <= 1'b0;
      else
         filter_done <= timer_done;
   end

   // Per-output gating and fault capture
   // A short frame neither loads commands nor clears status
   wire frame_done = cs_rise && spi_q == OSF_SHIFT && frame_full;
   genvar i;
   generate
      for (i = 0; i < NUM_OUT; i++) begin : g_out
         // Thermal shutdown is per output; it re-enables when cooled
         wire on_ok = cmd_q[i] & ~sen_s.thermal[i];
         // Over-voltage masks outputs; cmd_q is kept, so they resume
         wire on_d  = on_ok & ~sup_s.load_ov & ~sup_s.logic_uv;
         // Load-supply under-voltage deliberately not in the gate term
         wire ol_ev = ~cmd_q[i] & timer_done & sen_s.open_load[i];
         wire th_ev = cmd_q[i] & sen_s.thermal[i];
         wire ev    = en_s & (ol_ev | th_ev);
         // Clear only bits that went out in a complete frame
         wire clr   = frame_done & snap_q[i];

         // Gate state is kept while enable is low so outputs resume later
         always_ff @(posedge clk) begin
            if (reset || sup_s.logic_uv)
               gate_on[i] <= 1'b0;
            else
               gate_on[i] <= on_d;
         end

         always_ff @(posedge clk) begin
            if (reset)
               gate_drive_en[i] <= 1'b0;
            else
               gate_drive_en[i] <= en_s;
         end

         // Set wins over clear so an event in the read cycle is kept
         always_ff @(posedge clk) begin
            if (reset || sup_s.logic_uv)
               fault_status_reg[i] <= 1'b0;
            else if (ev)
               fault_status_reg[i] <= 1'b1;
            else if (clr)
               fault_status_reg[i] <= 1'b0;
         end
      end
   endgenerate
endmodule

// file: testbench/osf_fault_logic_sva.sv
// Pin checks for the fault logic.
// Pins are async; bounds allow the 3-clock sync path.
`timescale 1ns/100ps
module osf_fault_logic_sva
   import osf_pkg::*;
#(parameter int unsigned FILT_COUNT = FILT_CYCLES) (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // Serial pins
   input wire logic        cs_n,
   input wire logic        sclk,
   input wire logic        sdi,
   input wire logic        sdo,
   input wire logic        sdo_oe,
   // Control and sense
   input wire logic        enable,
   input wire osf_supply_s supply,
   input wire osf_sense_s  sense,
   // Outputs
   input wire logic [7:0]  gate_on,
   input wire logic [7:0]  gate_drive_en,
   input wire logic [7:0]  fault_status_reg,
   input wire logic        filter_done
);
   logic        cs_q;
   int unsigned cnt_q;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Cycles since chip select rose at the pin
   always_ff @(posedge clk) begin
      cs_q  <= cs_n;
      cnt_q <= (reset || (cs_n && !cs_q)) ? 0 : cnt_q + 1;
   end
   sequence s_cs_rise;
      !cs_n ##1 cs_n;
   endsequence
   sequence s_bit_clear;
      !supply.logic_uv[*6] ##0
         (|($past(fault_status_reg) & ~fault_status_reg));
   endsequence
   a_ov_all_off: assert property (
      supply.load_ov[*5] |-> gate_on == 8'h00) else $error("ov gate");
   a_uv_clear_all: assert property (
      supply.logic_uv[*5] |-> gate_on == 8'h00 &&
      fault_status_reg == 8'h00) else $error("uv clear");
   a_thermal_own: assert property (
      $stable(sense.thermal)[*5] |-> (gate_on & sense.thermal) == 8'h00)
      else $error("hot gate on");
   a_drive_off: assert property (
      !enable[*4] |-> gate_drive_en == 8'h00) else $error("drive off");
   a_drive_on: assert property (
      enable[*4] |-> gate_drive_en == 8'hff) else $error("drive on");
   a_sdo_float: assert property (
      cs_n[*5] |-> !sdo_oe) else $error("sdo driven");
   a_filter_restart: assert property (
      s_cs_rise |-> ##[1:6] !filter_done) else $error("no restart");
   a_filter_span: assert property (
      $rose(filter_done) |-> cnt_q inside {[FILT_COUNT:FILT_COUNT + 8]})
      else $error("filter span");
   a_status_held: assert property (
      s_bit_clear |-> cnt_q <= 8) else $error("status lost");
endmodule
bind osf_fault_logic osf_fault_logic_sva #(.FILT_COUNT(FILT_COUNT)) sva_i (.*);

// file: testbench/osf_mcu_model.sv
// Controller model running one 8-bit serial frame.
// Each sclk level is held 5 clocks to pass the sync.
`timescale 1ns/100ps
module osf_mcu_model (
   // Clock
   input  wire logic clk,
   // Serial pins
   output logic      cs_n,
   output logic      sclk,
   output logic      sdi,
   input  wire logic sdo,
   input  wire logic sdo_oe
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi  = 1'b0;
   end
   task automatic frame(input logic [7:0] cmd, output logic [7:0] st);
      @(posedge clk);
      #1 cs_n = 1'b0;
      repeat (6) @(posedge clk);
      for (int i = 7; i >= 0; i--) begin
         #1 sclk = 1'b1;
         sdi = cmd[i];
         repeat (5) @(posedge clk);
         #1 st[i] = sdo_oe ? sdo : 1'bx;
         sclk = 1'b0;
         repeat (5) @(posedge clk);
      end
      #1 cs_n = 1'b1;
      // Released line flips so nobody leans on a stale bit
      sdi = ~sdi;
      repeat (2) @(posedge clk);
      #1;
   endtask
endmodule

// file: testbench/tb_osf_fault_logic.sv
// Self-checking bench for the fault logic.
// Needs the controller model; the filter count is shortened.
`timescale 1ns/100ps
module tb_osf_fault_logic;
   import osf_pkg::*;
   localparam int unsigned FC = 20;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        enable = 1'b1;
   logic        cs_n, sclk, sdi, sdo, sdo_oe, filter_done;
   osf_supply_s supply = '0;
   osf_sense_s  sense = '0;
   logic [7:0]  gate_on, gate_drive_en, fault_status_reg, cmd, st;
   int          fails = 0;
   int          checks_done = 0;
   int          cyc = 0;
   always #10 clk = ~clk;
   osf_fault_logic #(.FILT_COUNT(FC)) osf_fault_logic_i (.clk(clk),
      .reset(reset), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
      .sdo_oe(sdo_oe), .enable(enable), .supply(supply), .sense(sense),
      .gate_on(gate_on), .gate_drive_en(gate_drive_en),
      .fault_status_reg(fault_status_reg), .filter_done(filter_done));
   osf_mcu_model osf_mcu_model_i (.clk(clk), .cs_n(cs_n), .sclk(sclk),
      .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
   function automatic logic [7:0] exp_gate(input logic [7:0] c, th,
                                           input logic ov);
      return ov ? 8'h00 : c & ~th;
   endfunction
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string n, input logic [7:0] s, e);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Ceiling is a few times the expected run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fails++;
         conclude();
      end
   end
   initial begin
      void'($urandom(25));
      step(16);
      reset = 1'b0;
      step(4);
      for (int i = 0; i < 3; i++) begin
         cmd = $urandom;
         osf_mcu_model_i.frame(cmd, st);
         step(6);
         chk("gate", gate_on, exp_gate(cmd, 8'h00, 1'b0));
      end
      cmd = (cmd & 8'h7f) | 8'h01;
      osf_mcu_model_i.frame(cmd, st);
      supply.load_ov = 1'b1;
      step(6);
      chk("ov", gate_on, exp_gate(cmd, 8'h00, 1'b1));
      supply.load_ov = 1'b0;
      supply.load_uv = 1'b1;
      step(6);
      chk("resume", gate_on, exp_gate(cmd, 8'h00, 1'b0));
      supply.load_uv = 1'b0;
      sense.thermal = 8'h01;
      step(6);
      chk("hot", gate_on, exp_gate(cmd, 8'h01, 1'b0));
      chk("hot stat", fault_status_reg, 8'h01);
      sense.thermal = 8'h00;
      step(6);
      chk("retry", gate_on, exp_gate(cmd, 8'h00, 1'b0));
      osf_mcu_model_i.frame(cmd, st);
      chk("read hot", st, 8'h01);
      // Bit 0 is commanded on, so only output eight may report
      sense.open_load = 8'h81;
      step(FC / 2);
      chk("filter", fault_status_reg, 8'h00);
      chk("timer run", {7'h00, filter_done}, 8'h00);
      step(FC + 10);
      chk("open", fault_status_reg, 8'h80);
      chk("timer done", {7'h00, filter_done}, 8'h01);
      sense.open_load = 8'h00;
      step(6);
      chk("latched", fault_status_reg, 8'h80);
      osf_mcu_model_i.frame(cmd, st);
      chk("read open", st, 8'h80);
      step(6);
      chk("cleared", fault_status_reg, 8'h00);
      sense.thermal = 8'h01;
      step(6);
      supply.logic_uv = 1'b1;
      sense.thermal = 8'h00;
      step(6);
      chk("uv gate", gate_on, 8'h00);
      chk("uv stat", fault_status_reg, 8'h00);
      supply.logic_uv = 1'b0;
      sense.open_load = 8'h02;
      step(FC + 30);
      chk("uv back", fault_status_reg, 8'h02);
      enable = 1'b0;
      sense.open_load = 8'h06;
      step(6);
      chk("en off", gate_drive_en, 8'h00);
      chk("en blind", fault_status_reg, 8'h02);
      enable = 1'b1;
      step(6);
      chk("en on", gate_drive_en, 8'hff);
      chk("en sees", fault_status_reg, 8'h06);
      conclude();
   end
endmodule
